// File: rtl/pps_pkg.sv
// Constants and types shared by the power sequencer block
// Notes on behaviour
// - Power-up is ten strobes separated by nine programmable delays.
// - A rail belongs to at most one strobe; a strobe may drive several rails.
// - Each delay between strobes is programmable from 2 ms to 5 ms.
// - Power-up fires strobe one at once, then each next strobe after its delay.
// - Off wakes on button fall, adapter fall, request high, or bias with adapter low.
// - Pre-off and sleep wake on button or adapter fall, or request high level.
// - A wake enters the wait-for-request state and runs power-up.
// - Wait times out after 20 s with pins high and no request, then powers down.
// - Request high moves to active; then request low powers down to sleep, adapter ignored.
// - Rails with strobe code zero keep their state through power-up and through power-down to sleep.
// - Rail enables are writable any time except while the sequencer runs or in the cycle a power-down starts.
// - Rail enable bits show the real state; the sequencer updates them itself.
// - Power-down runs strobes ten to one, disabling rails and enabling discharge.
// - Power-down delays are ten times longer under one global factor bit.
// - The final state is entered exactly 500 ms after power-down starts.
// - Button held low 8 s, or 15 s with long-reset, powers down.
// - Thermal shutdown, lockout or power-good failure trigger power-down.
// - Going to sleep leaves rails outside the sequencer as they were.
// - Toward off, free rails two to seven stop at start; switches two and three at entry.
// - Bias below threshold resets the core and drops every rail with discharge.
// - Strobes one and two serve only the two backup converters.
// - Strobes one and two fire on every power-up even when already on.
// - On power-down strobes two and one run only with the backup seal clear.
// - Power-good failure pulls power-good low and powers down at once.
package pps_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int MS_TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_W = 17;

  localparam int NUM_RAILS = 10;
  localparam int NUM_SEQ_RAILS = 8;
  localparam int BKP_RAILS = 2;
  localparam int NUM_DLY = 9;
  localparam int ASG_W = 4;
  localparam int DLY_W = 2;
  localparam int ASG_REG_W = NUM_SEQ_RAILS * ASG_W;
  localparam int DLY_REG_W = NUM_DLY * DLY_W;
  localparam int RAIL_LS2 = 8;
  localparam int RAIL_LS3 = 9;
  localparam logic [NUM_RAILS-1:0] FREE_OFF_MASK = 10'h0fc;

  localparam logic [3:0] STROBE_FIRST = 4'h1;
  localparam logic [3:0] STROBE_BKP_LAST = 4'h2;
  localparam logic [3:0] STROBE_LAST = 4'ha;
  localparam logic [3:0] STROBE_DONE = 4'h0;

  localparam int DLY_BASE_MS = 2;
  localparam int DLY_MAX_MS = 5;
  localparam int PD_FACTOR = 10;
  localparam int PD_TOTAL_MS = 500;
  localparam int WAIT_TIMEOUT_MS = 20000;
  localparam int HOLD_SHORT_MS = 8000;
  localparam int HOLD_LONG_MS = 15000;
  localparam int DCNT_W = 6;
  localparam int PD_W = 9;
  localparam int WAIT_W = 15;
  localparam int HOLD_W = 14;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_RAIL_EN = 12'h004;
  localparam logic [11:0] ADDR_STROBE_ASG = 12'h008;
  localparam logic [11:0] ADDR_DELAY = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;

  localparam int CTRL_W = 3;
  localparam int CTRL_DLYF_BIT = 0;
  localparam int CTRL_SEAL_BIT = 1;
  localparam int CTRL_LONG_BIT = 2;
  localparam int STAT_MODE_LSB = 6;
  localparam int STAT_PG_BIT = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h1;
  localparam logic [ASG_REG_W-1:0] ASG_RST = 32'h87654321;
  localparam logic [DLY_REG_W-1:0] DLY_RST = 18'h00000;

  typedef enum logic [5:0] {
    PPS_OFF = 6'h01,
    PPS_PRE_OFF = 6'h02,
    PPS_WAIT_FOR_REQUEST = 6'h04,
    PPS_ACTIVE = 6'h08,
    PPS_SUSPEND = 6'h10,
    PPS_RECOVERY = 6'h20
  } pps_state_e;

  typedef enum logic [2:0] {
    MODE_IDLE = 3'h1,
    MODE_UP = 3'h2,
    MODE_DOWN = 3'h4
  } pps_mode_e;
endpackage : pps_pkg

// File: rtl/pps_sync.sv
// Two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/1ns
module pps_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pps_sync_s;

  pps_sync_s q;
  pps_sync_s d;

  // First stage feeds only the second stage
  always_comb begin
    d.s1 = async_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.s2;
endmodule : pps_sync

// File: rtl/pps_sequencer.sv
// Power sequencer core: state machine, strobe sequencer and APB register file
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int MS_TICK = MS_TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic push_button_input_n_i,
  input wire logic adapter_detect_input_n_i,
  input wire logic power_request_pin_i,
  input wire logic thermal_shutdown_i,
  input wire logic undervoltage_lockout_i,
  input wire logic power_good_fail_i,
  input wire logic bias_present_i,
  input wire logic bias_low_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [NUM_RAILS-1:0] rail_enable_o,
  output logic [NUM_RAILS-1:0] discharge_o,
  output logic power_good_output_o
);
  typedef struct packed {
    pps_state_e st;
    pps_mode_e mode;
    pps_state_e dest;
    logic [3:0] idx;
    logic [DCNT_W-1:0] dcnt;
    logic [PD_W-1:0] pd_ms;
    logic [WAIT_W-1:0] wait_ms;
    logic [HOLD_W-1:0] hold_ms;
    logic [PRE_W-1:0] pre;
    logic [NUM_RAILS-1:0] en;
    logic [NUM_RAILS-1:0] dis;
    logic pg;
    logic [CTRL_W-1:0] ctrl;
    logic [ASG_REG_W-1:0] asg;
    logic [DLY_REG_W-1:0] dly;
    logic pb_prev;
    logic ac_prev;
    logic bias_prev;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } pps_core_s;

  localparam pps_core_s CORE_RST = '{st: PPS_OFF, mode: MODE_IDLE, dest: PPS_OFF, idx: STROBE_DONE,
    dcnt: '0, pd_ms: '0, wait_ms: '0, hold_ms: '0, pre: '0, en: '0, dis: '0, pg: 1'h0,
    ctrl: CTRL_RST, asg: ASG_RST, dly: DLY_RST, pb_prev: 1'h1, ac_prev: 1'h1, bias_prev: 1'h0,
    rdy: 1'h0, err: 1'h0, rdata: '0};

  // Rail may use strobe a: backups only 1-2, the rest only 3-10
  function automatic logic rail_valid(input logic [ASG_W-1:0] a, input int r);
    logic v;
    if (r < BKP_RAILS) begin
      v = (a >= STROBE_FIRST) && (a <= STROBE_BKP_LAST);
    end else begin
      v = (a > STROBE_BKP_LAST) && (a <= STROBE_LAST);
    end
    return v;
  endfunction : rail_valid

  // Rails driven by strobe k; one code per rail keeps each rail on one strobe
  function automatic logic [NUM_RAILS-1:0] strobe_mask(input logic [ASG_REG_W-1:0] asg, input logic [3:0] k);
    logic [NUM_RAILS-1:0] m;
    logic [ASG_W-1:0] a;
    m = '0;
    for (int r = 0; r < NUM_SEQ_RAILS; r++) begin
      a = asg[r*ASG_W +: ASG_W];
      m[r] = rail_valid(a, r) && (a == k);
    end
    return m;
  endfunction : strobe_mask

  // Rails under sequencer control; code zero leaves a rail alone
  function automatic logic [NUM_RAILS-1:0] seq_owned(input logic [ASG_REG_W-1:0] asg);
    logic [NUM_RAILS-1:0] m;
    m = '0;
    for (int r = 0; r < NUM_SEQ_RAILS; r++) begin
      m[r] = rail_valid(asg[r*ASG_W +: ASG_W], r);
    end
    return m;
  endfunction : seq_owned

  // Delay ci in ticks: 2 to 5 ms, ten times longer when stretched
  function automatic logic [DCNT_W-1:0] dly_ticks(input logic [DLY_REG_W-1:0] dly, input logic [3:0] ci,
                                                   input logic stretch);
    logic [DLY_W-1:0] c;
    logic [DCNT_W-1:0] ms;
    c = (int'(ci) < NUM_DLY) ? dly[int'(ci)*DLY_W +: DLY_W] : '0;
    ms = DCNT_W'(DLY_BASE_MS) + DCNT_W'(c);
    if (stretch) begin
      ms = DCNT_W'(int'(ms) * PD_FACTOR);
    end
    return ms;
  endfunction : dly_ticks

  pps_core_s q;
  pps_core_s d;
  logic [7:0] pins_s;
  logic pb_s, ac_s, req_s, ots_s, undervoltage_lockout_s, pgf_s, bias_s, bias_low_s;
  logic tick, pb_fall, ac_fall, bias_rise, lock, fault, in_run, acc, stretch;
  logic up_start, dn_start;
  pps_state_e dn_dest;
  logic [HOLD_W-1:0] hold_lim;
  logic [NUM_RAILS-1:0] owned;

  pps_sync #(
    .W(8),
    .RST_VAL(8'h03)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i({bias_low_i, bias_present_i, power_good_fail_i, undervoltage_lockout_i, thermal_shutdown_i,
              power_request_pin_i, adapter_detect_input_n_i, push_button_input_n_i}),
    .sync_o(pins_s)
  );
  assign {bias_low_s, bias_s, pgf_s, undervoltage_lockout_s, ots_s, req_s, ac_s, pb_s} = pins_s;

  always_comb begin
    d = q;
    owned = seq_owned(q.asg);
    tick = (q.pre == PRE_W'(MS_TICK - 1));
    d.pre = tick ? '0 : q.pre + PRE_W'(1);
    pb_fall = q.pb_prev & ~pb_s;
    ac_fall = q.ac_prev & ~ac_s;
    bias_rise = ~q.bias_prev & bias_s;
    d.pb_prev = pb_s;
    d.ac_prev = ac_s;
    d.bias_prev = bias_s;
    lock = undervoltage_lockout_s | ots_s;
    fault = lock | pgf_s;
    in_run = (q.st == PPS_WAIT_FOR_REQUEST) || (q.st == PPS_ACTIVE) || (q.st == PPS_SUSPEND);
    hold_lim = q.ctrl[CTRL_LONG_BIT] ? HOLD_W'(HOLD_LONG_MS) : HOLD_W'(HOLD_SHORT_MS);
    stretch = q.ctrl[CTRL_DLYF_BIT];

    // Millisecond timers for button hold and request wait
    if (pb_s) begin
      d.hold_ms = '0;
    end else if (tick && q.hold_ms != hold_lim) begin
      d.hold_ms = q.hold_ms + HOLD_W'(1);
    end
    if (q.st != PPS_WAIT_FOR_REQUEST) begin
      d.wait_ms = '0;
    end else if (tick && q.wait_ms != WAIT_W'(WAIT_TIMEOUT_MS)) begin
      d.wait_ms = q.wait_ms + WAIT_W'(1);
    end

    // APB slave, answer one cycle into the access phase
    acc = psel_i & penable_i & ~q.rdy;
    d.rdy = acc;
    d.err = 1'h0;
    d.rdata = '0;
    if (acc) begin
      unique case (paddr_i)
        ADDR_CTRL: begin
          if (pwrite_i) begin
            d.ctrl = pwdata_i[CTRL_W-1:0];
          end else begin
            d.rdata = 32'(q.ctrl);
          end
        end
        ADDR_RAIL_EN: begin
          if (q.mode != MODE_IDLE) begin
            d.err = 1'h1;
          end else if (pwrite_i) begin
            d.en = pwdata_i[NUM_RAILS-1:0];
            d.dis = q.dis & ~pwdata_i[NUM_RAILS-1:0];
          end else begin
            d.rdata = 32'(q.en);
          end
        end
        ADDR_STROBE_ASG: begin
          if (pwrite_i) begin
            d.asg = pwdata_i[ASG_REG_W-1:0];
          end else begin
            d.rdata = 32'(q.asg);
          end
        end
        ADDR_DELAY: begin
          if (pwrite_i) begin
            d.dly = pwdata_i[DLY_REG_W-1:0];
          end else begin
            d.rdata = 32'(q.dly);
          end
        end
        ADDR_STATUS: begin
          d.rdata = 32'({q.pg, q.mode, q.st});
        end
        default: begin
          d.err = 1'h1;
        end
      endcase
    end

    // Wake and shutdown decisions
    up_start = 1'h0;
    dn_start = 1'h0;
    dn_dest = PPS_OFF;
    if (q.mode != MODE_DOWN) begin
      if (in_run && fault) begin
        dn_start = 1'h1;
        dn_dest = PPS_RECOVERY;
      end else if (in_run && q.hold_ms == hold_lim) begin
        dn_start = 1'h1;
      end else if (q.st == PPS_WAIT_FOR_REQUEST && q.wait_ms == WAIT_W'(WAIT_TIMEOUT_MS) && pb_s && ac_s
                   && !req_s) begin
        dn_start = 1'h1;
      end else if (q.st == PPS_ACTIVE && !req_s) begin
        dn_start = 1'h1;
        dn_dest = PPS_SUSPEND;
      end else if (q.mode == MODE_IDLE && !lock) begin
        unique case (q.st)
          PPS_OFF: begin
            up_start = pb_fall | ac_fall | req_s | (bias_rise & ~ac_s);
          end
          PPS_PRE_OFF, PPS_SUSPEND: begin
            up_start = pb_fall | ac_fall | req_s;
          end
          PPS_RECOVERY: begin
            if (!fault) begin
              d.st = PPS_PRE_OFF;
            end
          end
          PPS_WAIT_FOR_REQUEST, PPS_ACTIVE: begin
            up_start = 1'h0;
          end
        endcase
      end
      if (q.st == PPS_WAIT_FOR_REQUEST && req_s && !dn_start) begin
        d.st = PPS_ACTIVE;
      end
    end

    // Strobe sequencer
    if (up_start) begin
      d.st = PPS_WAIT_FOR_REQUEST;
      d.mode = MODE_UP;
      d.pre = '0;
      d.en = d.en | strobe_mask(q.asg, STROBE_FIRST);
      d.dis = d.dis & ~strobe_mask(q.asg, STROBE_FIRST);
      d.idx = STROBE_FIRST + 4'h1;
      d.dcnt = dly_ticks(q.dly, 4'h0, 1'h0);
    end else if (dn_start) begin
      d.mode = MODE_DOWN;
      d.dest = dn_dest;
      d.pre = '0;
      d.pd_ms = '0;
      d.en = q.en & ~strobe_mask(q.asg, STROBE_LAST);
      d.dis = q.dis | strobe_mask(q.asg, STROBE_LAST);
      if (dn_dest != PPS_SUSPEND) begin
        d.en = d.en & ~(FREE_OFF_MASK & ~owned);
      end
      d.idx = STROBE_LAST - 4'h1;
      d.dcnt = dly_ticks(q.dly, STROBE_LAST - 4'h2, stretch);
    end else if (q.mode == MODE_UP && tick) begin
      if (q.dcnt == DCNT_W'(1)) begin
        d.en = q.en | strobe_mask(q.asg, q.idx);
        d.dis = q.dis & ~strobe_mask(q.asg, q.idx);
        if (q.idx == STROBE_LAST) begin
          d.mode = MODE_IDLE;
          d.idx = STROBE_DONE;
        end else begin
          d.idx = q.idx + 4'h1;
          d.dcnt = dly_ticks(q.dly, q.idx - 4'h1, 1'h0);
        end
      end else begin
        d.dcnt = q.dcnt - DCNT_W'(1);
      end
    end else if (q.mode == MODE_DOWN && tick) begin
      d.pd_ms = q.pd_ms + PD_W'(1);
      if (q.idx != STROBE_DONE) begin
        if (q.dcnt != DCNT_W'(1)) begin
          d.dcnt = q.dcnt - DCNT_W'(1);
        end else if (q.idx <= STROBE_BKP_LAST && q.ctrl[CTRL_SEAL_BIT]) begin
          d.idx = STROBE_DONE;
        end else begin
          d.en = q.en & ~strobe_mask(q.asg, q.idx);
          d.dis = q.dis | strobe_mask(q.asg, q.idx);
          d.idx = q.idx - 4'h1;
          d.dcnt = dly_ticks(q.dly, q.idx - 4'h2, stretch);
        end
      end
      if (q.pd_ms == PD_W'(PD_TOTAL_MS - 1)) begin
        d.mode = MODE_IDLE;
        d.st = q.dest;
        d.idx = STROBE_DONE;
        if (q.dest != PPS_SUSPEND) begin
          d.en[RAIL_LS2] = 1'h0;
          d.en[RAIL_LS3] = 1'h0;
        end
      end
    end

    // Power-good high only in a settled running state with no fault
    d.pg = (d.st == PPS_WAIT_FOR_REQUEST || d.st == PPS_ACTIVE) && d.mode == MODE_IDLE && !fault;

    if (bias_low_s) begin
      d = CORE_RST;
      d.dis = '1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata_o = q.rdata;
  assign pready_o = q.rdy;
  assign pslverr_o = q.err;
  assign rail_enable_o = q.en;
  assign discharge_o = q.dis;
  assign power_good_output_o = q.pg;

  logic core_rst;
  assign core_rst = rst_i | bias_low_s;

  chk_first_strobe: assert property (@(posedge ref_clk_i) disable iff (core_rst)
    up_start |=> ((q.en & strobe_mask(q.asg, STROBE_FIRST)) == strobe_mask(q.asg, STROBE_FIRST))
      && q.idx == 4'h2 && q.mode == MODE_UP)
    else $error("first strobe not fired at power-up start");

  chk_reverse_start: assert property (@(posedge ref_clk_i) disable iff (core_rst)
    dn_start |=> ((q.en & strobe_mask(q.asg, STROBE_LAST)) == '0)
      && ((q.dis & strobe_mask(q.asg, STROBE_LAST)) == strobe_mask(q.asg, STROBE_LAST)) && q.idx == 4'h9)
    else $error("power-down did not begin with strobe ten");

  chk_free_rails_keep: assert property (@(posedge ref_clk_i) disable iff (core_rst)
    (q.mode == MODE_UP && !dn_start) |=> (((q.en ^ $past(q.en)) & ~$past(owned)) == '0))
    else $error("unassigned rail changed during power-up");

  chk_busy_reject: assert property (@(posedge ref_clk_i) disable iff (core_rst)
    (acc && pwrite_i && paddr_i == ADDR_RAIL_EN && q.mode != MODE_IDLE)
      |=> pready_o && pslverr_o && $stable(q.en[RAIL_LS2]))
    else $error("rail enable write accepted while sequencing");

  chk_pd_total: assert property (@(posedge ref_clk_i) disable iff (core_rst)
    (q.mode == MODE_DOWN && tick && q.pd_ms == PD_W'(PD_TOTAL_MS - 1))
      |=> q.mode == MODE_IDLE && q.st == $past(q.dest))
    else $error("final state not entered at end of power-down");

  chk_pd_bound: assert property (@(posedge ref_clk_i) disable iff (core_rst)
    q.mode == MODE_DOWN |-> q.pd_ms < PD_W'(PD_TOTAL_MS))
    else $error("power-down interval overran");

  chk_delay_range: assert property (@(posedge ref_clk_i) disable iff (core_rst)
    q.mode == MODE_UP |-> q.dcnt <= DCNT_W'(DLY_MAX_MS) && q.dcnt != '0)
    else $error("power-up delay out of range");

  chk_seal_hold: assert property (@(posedge ref_clk_i) disable iff (core_rst)
    (q.mode == MODE_DOWN && q.ctrl[CTRL_SEAL_BIT] && !acc) |=> q.en[1:0] == $past(q.en[1:0]))
    else $error("backup rails changed with seal set");

  chk_fault_down: assert property (@(posedge ref_clk_i) disable iff (core_rst)
    (in_run && fault && q.mode != MODE_DOWN) |=> q.mode == MODE_DOWN && q.dest == PPS_RECOVERY && !q.pg)
    else $error("fault did not start power-down");

  chk_hold_trip: assert property (@(posedge ref_clk_i) disable iff (core_rst)
    (in_run && q.mode != MODE_DOWN && q.hold_ms == hold_lim) |-> dn_start ##1 q.mode == MODE_DOWN)
    else $error("long press did not power down");

  chk_bias_drop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    bias_low_s |=> rail_enable_o == '0 && discharge_o == '1 && q.st == PPS_OFF)
    else $error("bias loss did not drop all rails");

  cov_power_up: cover property (@(posedge ref_clk_i) disable iff (core_rst) up_start);
  cov_to_suspend: cover property (@(posedge ref_clk_i) disable iff (core_rst)
    q.mode == MODE_DOWN && q.dest == PPS_SUSPEND ##1 q.st == PPS_SUSPEND);
  cov_recovery: cover property (@(posedge ref_clk_i) disable iff (core_rst) q.st == PPS_RECOVERY);
  cov_active: cover property (@(posedge ref_clk_i) disable iff (core_rst) q.st == PPS_ACTIVE && q.pg);
endmodule : pps_sequencer

// File: sim/pps_host_model.sv
// Host model that drives the power request pin
`timescale 1ns/1ns
module pps_host_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic want_i,
  input wire logic [15:0] lag_i,
  output logic power_request_pin_o
);
  logic [15:0] cnt_q;

  // Raises the request after a chosen lag, drops it at once
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !want_i) begin
      cnt_q <= 16'h0000;
      power_request_pin_o <= 1'b0;
    end else if (cnt_q >= lag_i) begin
      power_request_pin_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule : pps_host_model

// File: sim/pps_sequencer_tb_top.sv
// Testbench for the power sequencer block
`timescale 1ns/1ns
module pps_sequencer_tb_top;
  import pps_pkg::*;
  localparam int TK = 2;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pb_n = 1'b1;
  logic pgf = 1'b0;
  logic want = 1'b0;
  logic [15:0] lag = 16'h0000;
  logic req;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_RAILS-1:0] rail_en;
  logic [NUM_RAILS-1:0] dis;
  logic pg;
  logic [31:0] rd;
  logic er;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0;
  int t1;
  int t2;

  pps_sequencer #(.MS_TICK(TK)) dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .push_button_input_n_i(pb_n),
    .adapter_detect_input_n_i(1'b1), .power_request_pin_i(req), .thermal_shutdown_i(1'b0),
    .undervoltage_lockout_i(1'b0), .power_good_fail_i(pgf), .bias_present_i(1'b0),
    .bias_low_i(1'b0), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rail_enable_o(rail_en), .discharge_o(dis), .power_good_output_o(pg)
  );

  pps_host_model host (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .want_i(want), .lag_i(lag), .power_request_pin_o(req)
  );

  always #5 ref_clk_i = ~ref_clk_i;

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_rail(input int i, input logic v, output int t);
    int n;
    n = 0;
    while (rail_en[i] !== v && n < 3000) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 3000) mismatches++;
    t = cyc;
  endtask : wait_rail

  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h00000001);
    apb(1'b0, ADDR_STROBE_ASG, 32'h0);
    check(rd, 32'h87654321);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h00000041);
    apb(1'b0, 12'h0f0, 32'h0);
    check({31'h0, er}, 32'h1);
    // Rail five left out of the sequence, first delay at its maximum
    apb(1'b1, ADDR_STROBE_ASG, 32'h87054321);
    apb(1'b1, ADDR_DELAY, 32'h00000003);
    pb_n <= 1'b0;
    wait_rail(0, 1'b1, t0);
    wait_rail(1, 1'b1, t1);
    check(32'(t1 - t0), 32'(5 * TK));
    wait_rail(7, 1'b1, t1);
    check(32'(t1 - t0), 32'(17 * TK));
    repeat (10 * TK) @(posedge ref_clk_i);
    check(32'(rail_en), 32'h0df);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h00000244);
    want <= 1'b1;
    pb_n <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h00000248);
    apb(1'b1, ADDR_RAIL_EN, 32'h000001ff);
    check({31'h0, er}, 32'h0);
    check(32'(rail_en), 32'h1ff);
    // Fault during active: power-down towards recovery
    pgf <= 1'b1;
    wait_rail(7, 1'b0, t1);
    check({30'h0, rail_en[8], rail_en[5]}, 32'h2);
    check({31'h0, pg}, 32'h0);
    wait_rail(6, 1'b0, t2);
    check(32'(t2 - t1), 32'(20 * TK));
    check({30'h0, dis[7:6]}, 32'h3);
    apb(1'b1, ADDR_RAIL_EN, 32'h000003ff);
    check({31'h0, er}, 32'h1);
    wait_rail(8, 1'b0, t2);
    check(32'(t2 - t1), 32'(460 * TK));
    check(32'(rail_en), 32'h000);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h00000060);
    want <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    pgf <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h00000042);
    // Sealed backups, slow host, then request low into suspend
    apb(1'b1, ADDR_CTRL, 32'h00000003);
    lag <= 16'd40;
    pb_n <= 1'b0;
    wait_rail(2, 1'b1, t0);
    pb_n <= 1'b1;
    want <= 1'b1;
    repeat (100) @(posedge ref_clk_i);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h00000248);
    want <= 1'b0;
    wait_rail(2, 1'b0, t0);
    repeat (1000) @(posedge ref_clk_i);
    check(32'(rail_en), 32'h003);
    check({31'h0, pg}, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h00000050);
    print_verdict();
  end
endmodule : pps_sequencer_tb_top
